/* File: rtl/rxm_top.sv */
`timescale 1ns/1ps
`include "rxm_defs.svh"
////////////////////////////////////////////////////////////////////////////////
// Contract
// [R1] Multi-segment messages gather in a context, and a message whose segments stop arriving returns timed out.
// [R2] A timed-out message's info word uses the layout of its own type, not of the last type seen.
// [R3] The descriptor packet kind is 31 for a type 11 message and 30 for a type 9 message.
// [R4] Type 11 with narrow device ids sets bit 9 of info word 2 exactly when the message timed out.
// [R5] Type 11 with wide device ids sets bit 10 of info word 2 exactly when the message timed out.
// [R6] Type 9 sets bit 16 of info word 2 exactly when the message timed out.
// [R7] Software using the timeout flags uses even stream identifiers and knows the device id width.
// [R8] A context stays allocated from the first segment of a message until its last segment.
// [R9] Context lookup compares message type as well as identification, so types never share a context.
// [R10] Identification is source, destination and the low six class bits or the six mailbox bits.
// [R11] A timeout or teardown returns the context to the free pool.
// [R12] A new message with no free context is refused and never enters reassembly.
// [R13] Disabling then enabling the receive message unit resets it.
// [R14] With reset isolation on, packets for other devices keep flowing while the device is in reset.
// [R15] Software clears isolation through the two isolation bits by read-modify-write.
// [R16] A reset of the receive message unit frees every context and drops partial messages.
////////////////////////////////////////////////////////////////////////////////

module rxm_top
   import rxm_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        arst_n,
   // Avalon-MM slave
   input  wire logic [31:0] avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // Message segments from the link
   input  wire logic        seg_valid,
   output logic             seg_ready,
   input  wire logic        seg_mtype,
   input  wire logic        seg_first,
   input  wire logic        seg_last,
   input  wire logic [15:0] seg_src_id,
   input  wire logic [15:0] seg_dest_id,
   input  wire logic [7:0]  seg_class_of_service,
   input  wire logic [5:0]  seg_mailbox,
   input  wire logic [15:0] seg_stream_identifier,
   // Rest of the device held in reset (pin)
   input  wire logic        dev_reset_req_n,
   // Forwarding path
   input  wire logic        fwd_in_valid,
   input  wire logic [31:0] fwd_in_word,
   output logic             fwd_out_valid,
   output logic [31:0]      fwd_out_word,
   // Descriptor outputs
   output logic             msg_valid,
   output logic [4:0]       msg_pkt_kind,
   output logic [31:0]      msg_psi_word2,
   output logic             msg_timed_out,
   output logic [1:0]       msg_ctx,
   // Interrupt
   output logic             irq
);

   rxm_top_st_t st_q;
   rxm_top_st_t st_d;

   rxm_tmr_if  tmr ();
   rxm_done_if dn ();

   logic        iso_c;
   logic        dev_rst_c;
   logic        rxu_on_c;
   logic        seg_fire_c;
   logic        hit_c;
   logic        free_ok_c;
   logic        seg_cmp_c;
   logic [1:0]  hit_i;
   logic [1:0]  free_i;
   logic [1:0]  tgt_i;
   logic [1:0]  exp_i;
   logic [5:0]  key_c;
   logic [3:0]  rel_c;
   logic [3:0]  busy_map;
   logic [2:0]  ev_c;
   logic [2:0]  clr_c;
   logic [31:0] ctrl_rd;
   logic [31:0] wr_m;

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [5:0] key6(input logic t11, input logic [7:0] class_of_service_field, input logic [5:0] mbox);
      return t11 ? mbox : class_of_service_field[5:0];
   endfunction

   function automatic logic ctx_hit(input rxm_ctx_t c, input logic t11, input logic [15:0] src,
                                    input logic [15:0] dst, input logic [5:0] key);
      return c.busy && c.mtype == rxm_mtype_t'(t11) && c.src == src && c.dst == dst &&
             key6(c.mtype, c.class_of_service_field, c.mbox) == key;
   endfunction

   function automatic logic [31:0] be_merge(input logic [31:0] cur, input logic [31:0] wd, input logic [3:0] be);
      logic [31:0] r;
      r = cur;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[8*b +: 8] = wd[8*b +: 8];
         end
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      for (int i = 0; i < `RXM_NCTX; i++) begin
         busy_map[i] = st_q.ctx[i].busy;
      end
   end

   always_comb begin
      st_d      = st_q;
      tmr.start = '0;
      tmr.stop  = '0;
      dn.req    = 1'b0;
      dn.mtype  = RXM_T9;
      dn.tt     = st_q.ttsel;
      dn.tmo    = 1'b0;
      dn.stream = seg_stream_identifier;
      dn.class_of_service_field    = seg_class_of_service;
      dn.mbox   = seg_mailbox;
      dn.ctx    = 2'h0;
      rel_c     = 4'h0;
      ev_c      = 3'h0;
      clr_c     = 3'h0;
      hit_c     = 1'b0;
      hit_i     = 2'h0;
      free_ok_c = 1'b0;
      free_i    = 2'h0;
      tgt_i     = 2'h0;
      exp_i     = 2'h0;
      seg_cmp_c = 1'b0;
      wr_m      = 32'h0000_0000;

      // Device reset pin crosses in through two flops
      st_d.drs1 = dev_reset_req_n;
      st_d.drs2 = st_q.drs1;
      dev_rst_c = ~st_q.drs2;
      iso_c     = st_q.mpc[`RXM_MPC_ISO_BIT] & st_q.tris[`RXM_TRIS_ISO_BIT];
      rxu_on_c  = st_q.en & ~dev_rst_c;

      // Forwarding survives a device reset only when isolated
      st_d.fwd_v = fwd_in_valid & (~dev_rst_c | iso_c);   // [R14]
      st_d.fwd_w = fwd_in_word;

      // Lookup; an expiring context no longer takes segments
      key_c = key6(seg_mtype, seg_class_of_service, seg_mailbox);   // [R10]
      for (int i = `RXM_NCTX-1; i >= 0; i--) begin
         if (ctx_hit(st_q.ctx[i], seg_mtype, seg_src_id, seg_dest_id, key_c) && !tmr.expire[i]) begin   // [R9]
            hit_c = 1'b1;
            hit_i = 2'(i);
         end
         if (!st_q.ctx[i].busy) begin
            free_ok_c = 1'b1;
            free_i    = 2'(i);
         end
         if (tmr.expire[i]) begin
            exp_i = 2'(i);
         end
      end

      seg_fire_c = seg_valid & st_q.seg_rdy;
      if (seg_fire_c) begin
         if (rxu_on_c && (hit_c || (seg_first && free_ok_c))) begin
            tgt_i = hit_c ? hit_i : free_i;
            if (!hit_c) begin
               st_d.ctx[tgt_i].mtype  = rxm_mtype_t'(seg_mtype);
               st_d.ctx[tgt_i].src    = seg_src_id;
               st_d.ctx[tgt_i].dst    = seg_dest_id;
               st_d.ctx[tgt_i].class_of_service_field    = seg_class_of_service;
               st_d.ctx[tgt_i].mbox   = seg_mailbox;
               st_d.ctx[tgt_i].stream = seg_stream_identifier;
            end
            if (seg_last) begin
               seg_cmp_c           = 1'b1;
               dn.req              = 1'b1;
               dn.mtype            = rxm_mtype_t'(seg_mtype);
               dn.ctx              = tgt_i;
               rel_c[tgt_i]        = 1'b1;                    // [R8]
               ev_c[`RXM_IRQ_DONE] = 1'b1;
            end else begin
               st_d.ctx[tgt_i].busy = 1'b1;                   // [R8]
               tmr.start[tgt_i]     = 1'b1;                   // [R1]
            end
         end else begin
            ev_c[`RXM_IRQ_DROP] = 1'b1;                       // [R12]
         end
      end

      // Timeouts wait for a cycle with no completing segment; expire holds
      if (rxu_on_c && !seg_cmp_c && |tmr.expire) begin
         dn.req             = 1'b1;
         dn.mtype           = st_q.ctx[exp_i].mtype;          // [R2]
         dn.tmo             = 1'b1;                           // [R1]
         dn.stream          = st_q.ctx[exp_i].stream;
         dn.class_of_service_field             = st_q.ctx[exp_i].class_of_service_field;
         dn.mbox            = st_q.ctx[exp_i].mbox;
         dn.ctx             = exp_i;
         rel_c[exp_i]       = 1'b1;                           // [R11]
         ev_c[`RXM_IRQ_TMO] = 1'b1;
      end

      // Register slave: one wait state, then the answer
      ctrl_rd                  = 32'h0000_0000;
      ctrl_rd[`RXM_CTRL_EN]    = st_q.en;
      ctrl_rd[`RXM_CTRL_TTSEL] = st_q.ttsel;
      st_d.wait_r              = 1'b1;
      if ((avs_read | avs_write) & st_q.wait_r) begin
         st_d.wait_r = 1'b0;
         if (avs_read) begin
            case (avs_address)
               `RXM_A_CTRL:    st_d.rdata = ctrl_rd;
               `RXM_A_IRQ_STS: st_d.rdata = {29'h0000_0000, st_q.sts};
               `RXM_A_IRQ_MSK: st_d.rdata = {29'h0000_0000, st_q.msk};
               `RXM_A_CTX_STS: st_d.rdata = {24'h00_0000, tmr.expire, busy_map};
               `RXM_A_MPC:     st_d.rdata = st_q.mpc;
               `RXM_A_TRIS:    st_d.rdata = st_q.tris;
               default:        st_d.rdata = 32'h0000_0000;
            endcase
         end
      end
      if (avs_write & ~st_q.wait_r) begin
         case (avs_address)
            `RXM_A_CTRL: begin
               wr_m       = be_merge(ctrl_rd, avs_writedata, avs_byteenable);
               st_d.en    = wr_m[`RXM_CTRL_EN];
               st_d.ttsel = wr_m[`RXM_CTRL_TTSEL];
               if (wr_m[`RXM_CTRL_TDN]) begin
                  rel_c[wr_m[`RXM_CTRL_TDX +: 2]] = 1'b1;     // [R11]
               end
            end
            `RXM_A_IRQ_STS: begin
               wr_m  = be_merge(32'h0000_0000, avs_writedata, avs_byteenable);
               clr_c = wr_m[2:0];
            end
            `RXM_A_IRQ_MSK: begin
               wr_m     = be_merge({29'h0000_0000, st_q.msk}, avs_writedata, avs_byteenable);
               st_d.msk = wr_m[2:0];
            end
            `RXM_A_MPC:  st_d.mpc = be_merge(st_q.mpc, avs_writedata, avs_byteenable);
            `RXM_A_TRIS: st_d.tris = be_merge(st_q.tris, avs_writedata, avs_byteenable);
            default: begin
            end
         endcase
      end

      // Release; a disabled unit holds every context free
      for (int i = 0; i < `RXM_NCTX; i++) begin
         if (rel_c[i] || !rxu_on_c) begin
            st_d.ctx[i].busy = 1'b0;                          // [R11] [R13] [R16]
            tmr.stop[i]      = 1'b1;
         end
      end

      // New events win over a clear in the same cycle
      st_d.sts     = (st_q.sts & ~clr_c) | ev_c;
      st_d.irq     = |(st_d.sts & st_d.msk);
      st_d.seg_rdy = rxu_on_c;
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         st_q        <= '0;
         st_q.en     <= `RXM_CTRL_EN_RST;
         st_q.mpc    <= `RXM_MPC_RST;
         st_q.tris   <= `RXM_TRIS_RST;
         st_q.wait_r <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   rxm_tmo_timer u_tmr (
      .clk_sys (clk_sys),
      .arst_n  (arst_n),
      .tmr     (tmr.tmr)
   );

   rxm_psi_build u_psi (
      .clk_sys       (clk_sys),
      .arst_n        (arst_n),
      .dn            (dn.dst),
      .msg_valid     (msg_valid),
      .msg_pkt_kind  (msg_pkt_kind),
      .msg_psi_word2 (msg_psi_word2),
      .msg_timed_out (msg_timed_out),
      .msg_ctx       (msg_ctx)
   );

   assign avs_readdata    = st_q.rdata;
   assign avs_waitrequest = st_q.wait_r;
   assign seg_ready       = st_q.seg_rdy;
   assign fwd_out_valid   = st_q.fwd_v;
   assign fwd_out_word    = st_q.fwd_w;
   assign irq             = st_q.irq;

   ////////////////////////////////////////////////////////////////////////////
   property p_tmo;
      @(posedge clk_sys) disable iff (!arst_n)
      rxu_on_c && (|tmr.expire) && !seg_cmp_c |=> msg_valid && msg_timed_out && !busy_map[$past(exp_i)];
   endproperty
   a_tmo: assert property (p_tmo) else $error("expired context not returned as timed out"); // [R1] [R11]

   property p_tkind;
      @(posedge clk_sys) disable iff (!arst_n)
      dn.req && dn.tmo |=> msg_pkt_kind == (($past(st_q.ctx[exp_i].mtype) == RXM_T11) ? 5'h1f : 5'h1e);
   endproperty
   a_tkind: assert property (p_tkind) else $error("timed-out message used the wrong type"); // [R2]

   property p_hold;
      @(posedge clk_sys) disable iff (!arst_n)
      st_q.ctx[0].busy && !rel_c[0] && rxu_on_c |=> st_q.ctx[0].busy;
   endproperty
   a_hold: assert property (p_hold) else $error("open context lost before its last segment"); // [R8]

   property p_sel;
      @(posedge clk_sys) disable iff (!arst_n)
      seg_fire_c && hit_c |-> st_q.ctx[hit_i].mtype == rxm_mtype_t'(seg_mtype) &&
         st_q.ctx[hit_i].src == seg_src_id && st_q.ctx[hit_i].dst == seg_dest_id &&
         (seg_mtype ? st_q.ctx[hit_i].mbox == seg_mailbox :
                      st_q.ctx[hit_i].class_of_service_field[5:0] == seg_class_of_service[5:0]);
   endproperty
   a_sel: assert property (p_sel) else $error("segment steered into a foreign context"); // [R9] [R10]

   property p_drop;
      @(posedge clk_sys) disable iff (!arst_n)
      seg_fire_c && seg_first && !hit_c && !free_ok_c |=> st_q.sts[2] && busy_map == $past(busy_map);
   endproperty
   a_drop: assert property (p_drop) else $error("message accepted with no free context"); // [R12]

   property p_dis;
      @(posedge clk_sys) disable iff (!arst_n)
      !rxu_on_c |=> busy_map == 4'h0 ##1 tmr.expire == 4'h0;
   endproperty
   a_dis: assert property (p_dis) else $error("disabled unit kept a context"); // [R13] [R16]

   property p_fwd;
      @(posedge clk_sys) disable iff (!arst_n)
      fwd_in_valid && iso_c |=> fwd_out_valid && fwd_out_word == $past(fwd_in_word);
   endproperty
   a_fwd: assert property (p_fwd) else $error("isolated forwarding stalled"); // [R14]

endmodule

/* File: rtl/rxm_defs.svh */
`ifndef RXM_DEFS_SVH
`define RXM_DEFS_SVH

// Timing
`define RXM_CLK_NS          25
`define RXM_SEG_TMO_NS      100000
`define RXM_SEG_TMO_CYC     (`RXM_SEG_TMO_NS / `RXM_CLK_NS)
`define RXM_NCTX            4

// Register byte addresses
`define RXM_A_CTRL          32'h0000_0000
`define RXM_A_IRQ_STS       32'h0000_0004
`define RXM_A_IRQ_MSK       32'h0000_0008
`define RXM_A_CTX_STS       32'h0000_000c
`define RXM_A_TRIS          32'h0231_00f0
`define RXM_A_MPC           32'h0235_0a2c

// Field positions
`define RXM_CTRL_EN         0
`define RXM_CTRL_TTSEL      1
`define RXM_CTRL_TDN        4
`define RXM_CTRL_TDX        8
`define RXM_MPC_ISO_BIT     12
`define RXM_TRIS_ISO_BIT    9
`define RXM_IRQ_DONE        0
`define RXM_IRQ_TMO         1
`define RXM_IRQ_DROP        2

// Reset values
`define RXM_CTRL_EN_RST     1'h1
`define RXM_MPC_RST         32'h0000_1000
`define RXM_TRIS_RST        32'h0000_0200

// Descriptor packet kinds and timeout flag positions in info word 2
`define RXM_KIND_T11        5'h1f
`define RXM_KIND_T9         5'h1e
`define RXM_PSI_T11_TT0_TMO 9
`define RXM_PSI_T11_TT1_TMO 10
`define RXM_PSI_T9_TMO      16

`endif

/* File: rtl/rxm_pkg.sv */
`include "rxm_defs.svh"

package rxm_pkg;

   typedef enum logic {
      RXM_T9  = 1'b0,
      RXM_T11 = 1'b1
   } rxm_mtype_t;

   typedef struct packed {
      logic        busy;
      rxm_mtype_t  mtype;
      logic [15:0] src;
      logic [15:0] dst;
      logic [15:0] stream;
      logic [7:0]  class_of_service_field;
      logic [5:0]  mbox;
   } rxm_ctx_t;

   typedef struct packed {
      rxm_ctx_t [`RXM_NCTX-1:0] ctx;
      logic                     en;
      logic                     ttsel;
      logic [31:0]              mpc;
      logic [31:0]              tris;
      logic [2:0]               sts;
      logic [2:0]               msk;
      logic                     wait_r;
      logic [31:0]              rdata;
      logic                     irq;
      logic                     seg_rdy;
      logic                     drs1;
      logic                     drs2;
      logic                     fwd_v;
      logic [31:0]              fwd_w;
   } rxm_top_st_t;

   typedef struct packed {
      logic [`RXM_NCTX-1:0][11:0] cnt;
      logic [`RXM_NCTX-1:0]       run;
      logic [`RXM_NCTX-1:0]       exp;
   } rxm_tmr_st_t;

   typedef struct packed {
      logic        valid;
      logic [4:0]  kind;
      logic [31:0] w2;
      logic        tmo;
      logic [1:0]  ctx;
   } rxm_psi_st_t;

endpackage

/* File: rtl/rxm_if.sv */
`timescale 1ns/1ps
`include "rxm_defs.svh"

interface rxm_tmr_if;
   logic [`RXM_NCTX-1:0] start;
   logic [`RXM_NCTX-1:0] stop;
   logic [`RXM_NCTX-1:0] expire;
   modport ctl (output start, output stop, input expire);
   modport tmr (input start, input stop, output expire);
endinterface

interface rxm_done_if;
   import rxm_pkg::*;
   logic        req;
   rxm_mtype_t  mtype;
   logic        tt;
   logic        tmo;
   logic [15:0] stream;
   logic [7:0]  class_of_service_field;
   logic [5:0]  mbox;
   logic [1:0]  ctx;
   modport src (output req, output mtype, output tt, output tmo, output stream, output class_of_service_field, output mbox, output ctx);
   modport dst (input req, input mtype, input tt, input tmo, input stream, input class_of_service_field, input mbox, input ctx);
endinterface

/* File: rtl/rxm_tmo_timer.sv */
`timescale 1ns/1ps
`include "rxm_defs.svh"

module rxm_tmo_timer
   import rxm_pkg::*;
(
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic arst_n,
   // Control from the context table
   rxm_tmr_if.tmr    tmr
);

   localparam logic [11:0] TMO_LAST = 12'(`RXM_SEG_TMO_CYC - 1);

   rxm_tmr_st_t st_q;
   rxm_tmr_st_t st_d;

   // Stop beats start so a teardown never leaves a live timer behind
   always_comb begin
      st_d = st_q;
      for (int i = 0; i < `RXM_NCTX; i++) begin
         if (tmr.stop[i]) begin
            st_d.run[i] = 1'b0;
            st_d.exp[i] = 1'b0;
            st_d.cnt[i] = 12'h000;
         end else if (tmr.start[i]) begin
            st_d.run[i] = 1'b1;
            st_d.exp[i] = 1'b0;
            st_d.cnt[i] = 12'h000;
         end else if (st_q.run[i]) begin
            if (st_q.cnt[i] == TMO_LAST) begin
               st_d.run[i] = 1'b0;
               st_d.exp[i] = 1'b1;                         // [R1]
            end else begin
               st_d.cnt[i] = st_q.cnt[i] + 12'h001;
            end
         end
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign tmr.expire = st_q.exp;

endmodule

/* File: rtl/rxm_psi_build.sv */
`timescale 1ns/1ps
`include "rxm_defs.svh"

module rxm_psi_build
   import rxm_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        arst_n,
   // Completed message
   rxm_done_if.dst          dn,
   // Descriptor outputs
   output logic             msg_valid,
   output logic [4:0]       msg_pkt_kind,
   output logic [31:0]      msg_psi_word2,
   output logic             msg_timed_out,
   output logic [1:0]       msg_ctx
);

   rxm_psi_st_t st_q;
   rxm_psi_st_t st_d;

   // Layout follows the type held by the message itself
   function automatic logic [31:0] psi_w2(input rxm_mtype_t mt, input logic tt, input logic tmo,
                                          input logic [15:0] stream, input logic [7:0] class_of_service_field,
                                          input logic [5:0] mbox);
      logic [31:0] w;
      w = 32'h0000_0000;
      if (mt == RXM_T11) begin
         w[5:0] = mbox;
         if (tt) begin
            w[`RXM_PSI_T11_TT1_TMO] = tmo;                 // [R5]
         end else begin
            w[`RXM_PSI_T11_TT0_TMO] = tmo;                 // [R4]
         end
      end else begin
         w[15:0]             = stream;
         w[`RXM_PSI_T9_TMO]  = tmo;                        // [R6]
         w[31:24]            = class_of_service_field;
      end
      return w;
   endfunction

   always_comb begin
      st_d       = st_q;
      st_d.valid = dn.req;
      if (dn.req) begin
         st_d.kind = (dn.mtype == RXM_T11) ? `RXM_KIND_T11 : `RXM_KIND_T9;  // [R3]
         st_d.w2   = psi_w2(dn.mtype, dn.tt, dn.tmo, dn.stream, dn.class_of_service_field, dn.mbox);
         st_d.tmo  = dn.tmo;
         st_d.ctx  = dn.ctx;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign msg_valid     = st_q.valid;
   assign msg_pkt_kind  = st_q.kind;
   assign msg_psi_word2 = st_q.w2;
   assign msg_timed_out = st_q.tmo;
   assign msg_ctx       = st_q.ctx;

   ////////////////////////////////////////////////////////////////////////////
   property p_kind;
      @(posedge clk_sys) disable iff (!arst_n)
      dn.req |=> msg_valid && msg_pkt_kind == (($past(dn.mtype) == RXM_T11) ? `RXM_KIND_T11 : `RXM_KIND_T9);
   endproperty
   a_kind: assert property (p_kind) else $error("packet kind does not follow message type"); // [R3]

   property p_t11_tt0;
      @(posedge clk_sys) disable iff (!arst_n)
      dn.req && dn.mtype == RXM_T11 && !dn.tt |=> msg_psi_word2[9] == $past(dn.tmo) && !msg_psi_word2[10];
   endproperty
   a_t11_tt0: assert property (p_t11_tt0) else $error("type 11 narrow id timeout flag wrong"); // [R4]

   property p_t11_tt1;
      @(posedge clk_sys) disable iff (!arst_n)
      dn.req && dn.mtype == RXM_T11 && dn.tt |=> msg_psi_word2[10] == $past(dn.tmo) && !msg_psi_word2[9];
   endproperty
   a_t11_tt1: assert property (p_t11_tt1) else $error("type 11 wide id timeout flag wrong"); // [R5]

   property p_t9;
      @(posedge clk_sys) disable iff (!arst_n)
      dn.req && dn.mtype == RXM_T9 |=> msg_psi_word2[16] == $past(dn.tmo) && msg_timed_out == $past(dn.tmo);
   endproperty
   a_t9: assert property (p_t9) else $error("type 9 timeout flag wrong"); // [R6]

endmodule

/* File: verif/rxm_lp.sv */
`timescale 1ns/1ps
module rxm_lp (
   // Segment link
   input  wire logic   clk_sys,
   input  wire logic   seg_ready,
   output logic        seg_valid, seg_mtype, seg_first, seg_last,
   output logic [15:0] seg_src_id, seg_dest_id, seg_stream_identifier,
   output logic [7:0]  seg_class_of_service,
   output logic [5:0]  seg_mailbox
);
   initial {seg_valid, seg_mtype, seg_first, seg_last, seg_src_id, seg_dest_id,
            seg_stream_identifier, seg_class_of_service, seg_mailbox} = '0;
   // Held until ready; released fields flip so a stale header never looks valid
   task automatic s(input logic mt, f, l, input logic [15:0] sr, input logic [7:0] cs, input logic [5:0] mb);
      @(posedge clk_sys);
      {seg_valid, seg_mtype, seg_first, seg_last} <= {1'h1, mt, f, l};
      {seg_src_id, seg_dest_id, seg_class_of_service, seg_mailbox} <= {sr, 16'h0002, cs, mb};
      seg_stream_identifier <= 16'h0a40;
      @(posedge clk_sys);
      while (seg_ready !== 1'h1) @(posedge clk_sys);
      seg_valid <= 1'h0;
      {seg_src_id, seg_class_of_service, seg_mailbox} <= ~{sr, cs, mb};
   endtask
endmodule

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
`include "rxm_defs.svh"
module tb_top;
   logic        clk_sys = 0, arst_n = 0, avs_read = 0, avs_write = 0, dev_reset_req_n = 1, fwd_in_valid = 0;
   logic [31:0] avs_address = 0, avs_writedata = 0, fwd_in_word = 32'h5a, avs_readdata, fwd_out_word;
   logic [31:0] msg_psi_word2, d;
   logic [3:0]  avs_byteenable = 4'hf;
   logic [4:0]  msg_pkt_kind;
   logic [1:0]  msg_ctx;
   logic        avs_waitrequest, seg_valid, seg_ready, seg_mtype, seg_first, seg_last;
   logic        fwd_out_valid, msg_valid, msg_timed_out, irq;
   logic [15:0] seg_src_id, seg_dest_id, seg_stream_identifier;
   logic [7:0]  seg_class_of_service;
   logic [5:0]  seg_mailbox;
   int          m_n = 0, n_checks = 0, n_mismatch = 0;
   rxm_top i_rxm_top (.*);
   rxm_lp  i_rxm_lp (.*);
   always #12.5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) m_n <= m_n + int'(msg_valid === 1'h1);
   ////////////////////////////////////////////////////////////////////////////////
   task automatic cy(int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic chk(input logic [31:0] sn, ex);
      n_checks++;
      if (sn !== ex) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, sn, ex);
      end
   endtask
   task automatic bus(input logic w, input logic [31:0] a, wd);
      @(posedge clk_sys);
      {avs_write, avs_read, avs_address, avs_writedata} <= {w, !w, a, wd};
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'h0) @(posedge clk_sys);
      d = avs_readdata;
      {avs_write, avs_read} <= 2'h0;
   endtask
   task automatic wrap_up;
      if (n_mismatch == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      cy(20000);
      n_mismatch++;
      wrap_up();
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      cy(3);
      arst_n <= 1'h1;
      bus(0, `RXM_A_MPC, 0);
      chk(d, 32'h1000);
      bus(0, `RXM_A_TRIS, 0);
      chk(d, 32'h200);
      bus(0, 32'h40, 0);
      chk(d, 0);
      i_rxm_lp.s(1, 1, 1, 16'h1, 8'h0, 6'h2a);
      cy(3);
      chk({m_n[3:0], msg_pkt_kind, msg_psi_word2[9], msg_psi_word2[5:0]}, {4'h1, 5'h1f, 1'h0, 6'h2a});
      // Context is held between first and last segment
      i_rxm_lp.s(0, 1, 0, 16'h1, 8'hc5, 6'h0);
      bus(0, `RXM_A_CTX_STS, 0);
      chk(d[3:0] != 0, 1);
      i_rxm_lp.s(0, 0, 1, 16'h1, 8'hc5, 6'h0);
      cy(3);
      chk({msg_pkt_kind, msg_psi_word2[16:0]}, {5'h1e, 17'h0a40});
      // Type 9 with the same identification must not steal the open type 11 context
      bus(1, `RXM_A_CTRL, 3);
      i_rxm_lp.s(1, 1, 0, 16'h1, 8'h0, 6'h05);
      i_rxm_lp.s(0, 1, 1, 16'h1, 8'hc5, 6'h0);
      cy(3);
      chk({m_n[3:0], msg_pkt_kind, msg_timed_out}, {4'h3, 5'h1e, 1'h0});
      cy(4100);
      chk({m_n[3:0], msg_pkt_kind, msg_timed_out, msg_psi_word2[10], msg_psi_word2[5:0], msg_ctx},
          {4'h4, 5'h1f, 1'h1, 1'h1, 6'h05, 2'h0});
      // Timed-out context is back in the pool, so four open and the fifth drops
      for (int i = 0; i < 5; i++) i_rxm_lp.s(1, 1, 0, 16'h10 + 16'(i), 8'h0, 6'h1);
      bus(0, `RXM_A_CTX_STS, 0);
      chk(d[3:0], 4'hf);
      bus(0, `RXM_A_IRQ_STS, 0);
      chk(d[2], 1);
      bus(1, `RXM_A_IRQ_MSK, 4);
      cy(3);
      chk(irq, 1);
      bus(1, `RXM_A_CTRL, 0);
      bus(1, `RXM_A_CTRL, 1);
      bus(0, `RXM_A_CTX_STS, 0);
      chk(d[3:0], 0);
      // Teardown of one open context hands it back to the pool
      i_rxm_lp.s(1, 1, 0, 16'h20, 8'h0, 6'h3);
      bus(1, `RXM_A_CTRL, 32'h11);
      bus(0, `RXM_A_CTX_STS, 0);
      chk(d[3:0], 0);
      bus(1, `RXM_A_IRQ_STS, 7);
      cy(3);
      chk(irq, 0);
      // Forwarding survives device reset only while isolation is on
      dev_reset_req_n <= 1'h0;
      fwd_in_valid <= 1'h1;
      cy(4);
      chk({seg_ready, fwd_out_valid, fwd_out_word[29:0]}, {1'h0, 1'h1, 30'h5a});
      bus(0, `RXM_A_MPC, 0);
      bus(1, `RXM_A_MPC, d & ~32'h1000);
      bus(0, `RXM_A_TRIS, 0);
      bus(1, `RXM_A_TRIS, d & ~32'h200);
      cy(3);
      chk(fwd_out_valid, 0);
      wrap_up();
   end
endmodule
